// ===== rtl/acd_consts.svh
// register map, field positions, reset values of the audio clock divider configuration
`ifndef ACD_CONSTS_SVH
`define ACD_CONSTS_SVH

`define ACD_OFS_ANA_RATIO 8'h3e
`define ACD_OFS_CORE_EN 8'h44
`define ACD_OFS_CONV_EN 8'h45
`define ACD_OFS_CLKOUT_SEL 8'h46

`define ACD_RST_ANA_RATIO 6'h01
`define ACD_RST_CORE_EN 3'h0
`define ACD_RST_CONV_EN 8'h00
`define ACD_RST_CLKOUT_SEL 3'h0

`define ACD_ANA_W 6
`define ACD_ANA_ZERO_RATIO 7'h40
`define ACD_NUM_DIV 11
`define ACD_DIV_W 8
`define ACD_NUM_SRC 6

`define ACD_BIT_FEEDBACK 2
`define ACD_BIT_PRESCALE 1
`define ACD_BIT_PULSE_DENSITY 0
`define ACD_BIT_ADC_SHAPER 7
`define ACD_BIT_ADC_MOD 6
`define ACD_BIT_DAC_SHAPER 5
`define ACD_BIT_DAC_MOD 4
`define ACD_BIT_PRI_BCLK 3
`define ACD_BIT_SEC_BCLK 2
`define ACD_BIT_PRI_FSYNC 1
`define ACD_BIT_SEC_FSYNC 0

`endif

// ===== rtl/acd_pkg.sv
// types shared by the audio clock divider configuration block
package acd_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acd_reg_req_t;

  typedef enum logic [2:0] {
    ACD_SRC_PLL = 3'h0,
    ACD_SRC_PRI_BCLK = 3'h1,
    ACD_SRC_SEC_BCLK = 3'h2,
    ACD_SRC_CTRL_BUS = 3'h3,
    ACD_SRC_OSC = 3'h4,
    ACD_SRC_DSP = 3'h5
  } acd_clkout_src_t;

endpackage : acd_pkg

// ===== rtl/acd_divider.sv
// enable-gated divider producing one tick every ratio cycles; ratio 0 means 2**W
`timescale 1ns/10ps
`include "acd_consts.svh"

module acd_divider #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic en,
  input wire logic [W-1:0] ratio,
  output logic tick_r
);

  logic [W-1:0] count_r;
  logic [W-1:0] last;
  logic at_last;

  // ratio minus one wraps so that code zero gives the full 2**W period
  assign last = W'(ratio - 1'b1);
  assign at_last = (count_r == last);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
      tick_r <= 1'b0;
    end else if (!en) begin
      count_r <= '0;
      tick_r <= 1'b0;
    end else begin
      count_r <= at_last ? '0 : W'(count_r + 1'b1);
      tick_r <= at_last;
    end
  end

  // helper: cycles since previous tick, for the period check
  // a ratio change mid-period gives one odd gap, so the check rearms after it
  logic [W:0] gap_r;
  logic seen_r;
  logic [W-1:0] ratio_d_r;
  logic ratio_moved;
  assign ratio_moved = (ratio != ratio_d_r);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gap_r <= '0;
      seen_r <= 1'b0;
      ratio_d_r <= '0;
    end else begin
      ratio_d_r <= ratio;
      if (!en || ratio_moved) begin
        gap_r <= '0;
        seen_r <= 1'b0;
      end else begin
        gap_r <= tick_r ? (W+1)'(1) : (W+1)'(gap_r + 1'b1);
        seen_r <= seen_r | tick_r;
      end
    end
  end

  property p_div_off_low;
    @(posedge clock) disable iff (!nrst) !en |=> !tick_r;
  endproperty
  a_div_off_low: assert property (p_div_off_low) else $error("divider ticked while disabled");

  property p_div_period;
    @(posedge clock) disable iff (!nrst)
      tick_r && seen_r && en && $past(en) && $stable(ratio)
      |-> gap_r == ((ratio == '0) ? (W+1)'(1 << W) : (W+1)'(ratio));
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider period differs from ratio");

endmodule : acd_divider

// ===== rtl/acd_clock_config.sv
// register file and divider gating for the audio clock tree configuration
`timescale 1ns/10ps
`include "acd_consts.svh"

module acd_clock_config (
  input wire logic clock,
  input wire logic nrst,
  input wire acd_pkg::acd_reg_req_t reg_req,
  output logic [7:0] reg_rdata_r,
  input wire logic auto_detect_en,
  input wire logic [5:0] auto_ana_ratio,
  input wire logic [10:0][7:0] div_ratio,
  input wire logic [5:0] clkout_src_ticks,
  output logic ana_tick_r,
  output logic [10:0] div_tick_r,
  output logic [2:0] clock_output_source_select_r,
  output logic clkout_src_tick_r
);

  logic [5:0] analog_ratio_divider_value_r;
  logic [2:0] core_en_r;
  logic [7:0] conv_en_r;

  // address decode
  logic hit_ana;
  logic hit_core;
  logic hit_conv;
  logic hit_sel;
  assign hit_ana = (reg_req.addr == `ACD_OFS_ANA_RATIO);
  assign hit_core = (reg_req.addr == `ACD_OFS_CORE_EN);
  assign hit_conv = (reg_req.addr == `ACD_OFS_CONV_EN);
  assign hit_sel = (reg_req.addr == `ACD_OFS_CLKOUT_SEL);

  // individual enables, named for readability
  logic feedback_divider_enable;
  logic prescale_divider_enable;
  logic pulse_density_divider_enable;
  logic adc_mismatch_shaper_divider_enable;
  logic adc_modulator_divider_enable;
  logic dac_mismatch_shaper_divider_enable;
  logic dac_modulator_divider_enable;
  logic primary_port_bitclock_divider_enable;
  logic secondary_port_bitclock_divider_enable;
  logic primary_port_framesync_divider_enable;
  logic secondary_port_framesync_divider_enable;
  assign feedback_divider_enable = core_en_r[`ACD_BIT_FEEDBACK];
  assign prescale_divider_enable = core_en_r[`ACD_BIT_PRESCALE];
  assign pulse_density_divider_enable = core_en_r[`ACD_BIT_PULSE_DENSITY];
  assign adc_mismatch_shaper_divider_enable = conv_en_r[`ACD_BIT_ADC_SHAPER];
  assign adc_modulator_divider_enable = conv_en_r[`ACD_BIT_ADC_MOD];
  assign dac_mismatch_shaper_divider_enable = conv_en_r[`ACD_BIT_DAC_SHAPER];
  assign dac_modulator_divider_enable = conv_en_r[`ACD_BIT_DAC_MOD];
  assign primary_port_bitclock_divider_enable = conv_en_r[`ACD_BIT_PRI_BCLK];
  assign secondary_port_bitclock_divider_enable = conv_en_r[`ACD_BIT_SEC_BCLK];
  assign primary_port_framesync_divider_enable = conv_en_r[`ACD_BIT_PRI_FSYNC];
  assign secondary_port_framesync_divider_enable = conv_en_r[`ACD_BIT_SEC_FSYNC];

  // divider slot order: 10..3 converter and port dividers, 2..0 core dividers
  logic [10:0] div_en;
  assign div_en = {adc_mismatch_shaper_divider_enable, adc_modulator_divider_enable,
                   dac_mismatch_shaper_divider_enable, dac_modulator_divider_enable,
                   primary_port_bitclock_divider_enable, secondary_port_bitclock_divider_enable,
                   primary_port_framesync_divider_enable, secondary_port_framesync_divider_enable,
                   feedback_divider_enable, prescale_divider_enable, pulse_density_divider_enable};

  // register writes store only the field bits, so reserved bits cannot be set
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      analog_ratio_divider_value_r <= `ACD_RST_ANA_RATIO;
      core_en_r <= `ACD_RST_CORE_EN;
      conv_en_r <= `ACD_RST_CONV_EN;
      clock_output_source_select_r <= `ACD_RST_CLKOUT_SEL;
    end else if (reg_req.wr) begin
      if (hit_ana) analog_ratio_divider_value_r <= reg_req.wdata[5:0];
      if (hit_core) core_en_r <= reg_req.wdata[2:0];
      if (hit_conv) conv_en_r <= reg_req.wdata;
      if (hit_sel) clock_output_source_select_r <= reg_req.wdata[2:0];
    end
  end

  // read mux; reserved bits and unmapped addresses return zero
  logic [7:0] rd_mux;
  assign rd_mux = hit_ana ? {2'h0, analog_ratio_divider_value_r} :
                  hit_core ? {5'h00, core_en_r} :
                  hit_conv ? conv_en_r :
                  hit_sel ? {5'h00, clock_output_source_select_r} : 8'h00;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata_r <= rd_mux;
    end
  end

  // analog ratio: auto detection overrides the programmed code
  logic [5:0] ana_code;
  logic [6:0] ana_ratio_eff;
  assign ana_code = auto_detect_en ? auto_ana_ratio : analog_ratio_divider_value_r;
  assign ana_ratio_eff = (ana_code == 6'h00) ? `ACD_ANA_ZERO_RATIO : {1'b0, ana_code};

  acd_divider #(.W(`ACD_ANA_W)) u_ana_div (
    .clock(clock),
    .nrst(nrst),
    .en(1'b1),
    .ratio(ana_code),
    .tick_r(ana_tick_r)
  );

  for (genvar i = 0; i < `ACD_NUM_DIV; i++) begin : g_div
    acd_divider #(.W(`ACD_DIV_W)) u_div (
      .clock(clock),
      .nrst(nrst),
      .en(div_en[i]),
      .ratio(div_ratio[i]),
      .tick_r(div_tick_r[i])
    );
  end

  // source mux for the clock output divider; reserved codes give a quiet output
  logic sel_legal;
  logic src_pick;
  assign sel_legal = (clock_output_source_select_r <= 3'(acd_pkg::ACD_SRC_DSP));
  assign src_pick = sel_legal ? clkout_src_ticks[clock_output_source_select_r] : 1'b0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clkout_src_tick_r <= 1'b0;
    end else begin
      clkout_src_tick_r <= src_pick;
    end
  end

  // checks
  property p_ana_zero;
    @(posedge clock) disable iff (!nrst)
      !auto_detect_en && analog_ratio_divider_value_r == 6'h00 |-> ana_ratio_eff == 7'h40;
  endproperty
  a_ana_zero: assert property (p_ana_zero) else $error("analog code zero must divide by 64");

  property p_auto_override;
    @(posedge clock) disable iff (!nrst)
      auto_detect_en |-> ana_code == auto_ana_ratio;
  endproperty
  a_auto_override: assert property (p_auto_override) else $error("auto ratio not used");

  property p_reserved_zero;
    @(posedge clock) disable iff (!nrst)
      reg_req.rd && (hit_core || hit_sel) |=> reg_rdata_r[7:3] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_core_write;
    @(posedge clock) disable iff (!nrst)
      reg_req.wr && hit_core |=> core_en_r == $past(reg_req.wdata[2:0]);
  endproperty
  a_core_write: assert property (p_core_write) else $error("core enables not written");

  property p_adc_shaper_off;
    @(posedge clock) disable iff (!nrst)
      reg_req.wr && hit_conv && !reg_req.wdata[7] |=> ##1 !div_tick_r[10];
  endproperty
  a_adc_shaper_off: assert property (p_adc_shaper_off) else $error("adc shaper divider ran disabled");

  property p_pri_bclk_on;
    @(posedge clock) disable iff (!nrst)
      reg_req.wr && hit_conv && reg_req.wdata[3] && div_ratio[6] == 8'h08 && !conv_en_r[3]
      |=> ##8 div_tick_r[6];
  endproperty
  a_pri_bclk_on: assert property (p_pri_bclk_on) else $error("primary bit-clock divider idle");

  property p_sec_fsync_readback;
    @(posedge clock) disable iff (!nrst)
      reg_req.wr && hit_conv ##1 !reg_req.wr ##1 reg_req.rd && hit_conv && !reg_req.wr
      |=> reg_rdata_r[0] == $past(reg_req.wdata[0], 3);
  endproperty
  a_sec_fsync_readback: assert property (p_sec_fsync_readback) else $error("fsync enable readback wrong");

  property p_sel_reserved;
    @(posedge clock) disable iff (!nrst)
      clock_output_source_select_r[2:1] == 2'b11 |=> !clkout_src_tick_r;
  endproperty
  a_sel_reserved: assert property (p_sel_reserved) else $error("reserved source passed a clock");

  property p_disabled_low;
    @(posedge clock) disable iff (!nrst)
      div_en == 11'h000 [*2] |-> div_tick_r == 11'h000;
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("disabled divider output not low");

  property p_reset_state;
    @(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> conv_en_r == 8'h00 && core_en_r == 3'h0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("enables not cleared by reset");

  c_auto: cover property (@(posedge clock) disable iff (!nrst) auto_detect_en && ana_tick_r);
  c_all_on: cover property (@(posedge clock) disable iff (!nrst) div_en == 11'h7ff);
  c_dsp_src: cover property (@(posedge clock) disable iff (!nrst)
    clock_output_source_select_r == 3'h5 && clkout_src_tick_r);
  c_reenable: cover property (@(posedge clock) disable iff (!nrst) !div_en[4] ##1 div_en[4]);

endmodule : acd_clock_config

// ===== verification/tb.sv
// self-checking bench for the audio clock divider configuration
`timescale 1ns/10ps
`include "acd_consts.svh"

module tb;
  logic clock;
  logic nrst;
  acd_pkg::acd_reg_req_t reg_req;
  logic [7:0] reg_rdata_r;
  logic auto_detect_en;
  logic [5:0] auto_ana_ratio;
  logic [10:0][7:0] div_ratio;
  logic [5:0] clkout_src_ticks;
  logic ana_tick_r;
  logic [10:0] div_tick_r;
  logic [2:0] clock_output_source_select_r;
  logic clkout_src_tick_r;
  logic [11:0] ticks;
  logic [10:0] seen;
  logic [7:0] a;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int p;
  int n;
  logic [7:0] ofs[5] = '{8'h3e, 8'h44, 8'h45, 8'h46, 8'h47};
  logic [7:0] msk[5] = '{8'h3f, 8'h07, 8'hff, 8'h07, 8'h00};
  logic [5:0] codes[5] = '{6'h01, 6'h02, 6'h05, 6'h3f, 6'h00};
  int exp_ana[5] = '{1, 2, 5, 63, 64};

  assign ticks = {ana_tick_r, div_tick_r};

  acd_clock_config u_acd_clock_config (
    .clock(clock),
    .nrst(nrst),
    .reg_req(reg_req),
    .reg_rdata_r(reg_rdata_r),
    .auto_detect_en(auto_detect_en),
    .auto_ana_ratio(auto_ana_ratio),
    .div_ratio(div_ratio),
    .clkout_src_ticks(clkout_src_ticks),
    .ana_tick_r(ana_tick_r),
    .div_tick_r(div_tick_r),
    .clock_output_source_select_r(clock_output_source_select_r),
    .clkout_src_tick_r(clkout_src_tick_r)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task chk_v(input logic [11:0] got, input logic [11:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk_v

  task chk_n(input int got, input int exp, input string msg);
    comparisons++;
    if (got != exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, msg, got, exp);
    end
  endtask : chk_n

  // one idle cycle after each access keeps strobes from toggling in one step
  task wr(input logic [7:0] ad, input logic [7:0] d);
    reg_req.wr = 1'b1;
    reg_req.addr = ad;
    reg_req.wdata = d;
    @(negedge clock);
    reg_req.wr = 1'b0;
    @(negedge clock);
  endtask : wr

  task rd(input logic [7:0] ad, input logic [7:0] e);
    reg_req.rd = 1'b1;
    reg_req.addr = ad;
    @(negedge clock);
    reg_req.rd = 1'b0;
    chk_v({4'h0, reg_rdata_r}, {4'h0, e}, "register read");
    @(negedge clock);
  endtask : rd

  // cycles between two ticks; bounded so a dead divider cannot hang
  task gap(input int i, output int g);
    n = 0;
    g = 0;
    while (ticks[i] !== 1'b1 && n < 600) begin
      @(negedge clock);
      n++;
    end
    do begin
      @(negedge clock);
      g++;
    end while (ticks[i] !== 1'b1 && g < 600);
  endtask : gap

  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      give_verdict;
    end
  end

  initial begin
    reg_req = '0;
    nrst = 1'b0;
    auto_detect_en = 1'b0;
    auto_ana_ratio = 6'h03;
    clkout_src_ticks = 6'h00;
    for (int k = 0; k < 11; k++) div_ratio[k] = 8'(k + 2);
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    for (int k = 0; k < 4; k++) rd(ofs[k], (k == 0) ? 8'h01 : 8'h00);
    chk_v({1'b0, div_tick_r}, 12'h000, "ticks idle after reset");
    // reserved bits written as zero; the unmapped place ignores a full write
    for (int k = 0; k < 5; k++) begin
      wr(ofs[k], (k == 4) ? 8'hff : msk[k]);
      rd(ofs[k], msk[k]);
    end
    wr(`ACD_OFS_CORE_EN, 8'h00);
    wr(`ACD_OFS_CONV_EN, 8'h00);
    for (int k = 0; k < 11; k++) begin
      a = (k < 3) ? `ACD_OFS_CORE_EN : `ACD_OFS_CONV_EN;
      wr(a, 8'h01 << ((k < 3) ? k : k - 3));
      n = 0;
      while (div_tick_r[k] !== 1'b1 && n < 300) begin
        @(negedge clock);
        n++;
      end
      // ratio cycles after the write edge, one of them spent inside wr
      chk_n(n, k + 1, "first tick after enable");
      seen = '0;
      repeat (30) begin
        @(negedge clock);
        seen |= div_tick_r;
      end
      chk_v({1'b0, seen}, {1'b0, 11'h001 << k}, "enable reaches its divider only");
      gap(k, p);
      chk_n(p, k + 2, "divider period");
      wr(a, 8'h00);
      seen = '0;
      repeat (20) begin
        @(negedge clock);
        seen |= div_tick_r;
      end
      chk_v({1'b0, seen}, 12'h000, "disabled divider stays low");
    end
    for (int k = 0; k < 5; k++) begin
      wr(`ACD_OFS_ANA_RATIO, {2'b00, codes[k]});
      gap(11, p);
      gap(11, p);
      chk_n(p, exp_ana[k], "analog ratio period");
    end
    wr(`ACD_OFS_ANA_RATIO, 8'h0a);
    auto_detect_en = 1'b1;
    gap(11, p);
    gap(11, p);
    chk_n(p, 3, "automatic ratio overrides code");
    auto_detect_en = 1'b0;
    gap(11, p);
    gap(11, p);
    chk_n(p, 10, "programmed ratio back in use");
    for (int s = 0; s < 8; s++) begin
      wr(`ACD_OFS_CLKOUT_SEL, 8'(s));
      rd(`ACD_OFS_CLKOUT_SEL, 8'(s));
      chk_v({9'h000, clock_output_source_select_r}, 12'(s), "source select field");
      clkout_src_ticks = (s < 6) ? 6'(6'h01 << s) : 6'h3f;
      @(negedge clock);
      chk_v({11'h000, clkout_src_tick_r}, (s < 6) ? 12'h001 : 12'h000, "selected source passes");
      clkout_src_ticks = 6'h3f ^ clkout_src_ticks;
      @(negedge clock);
      chk_v({11'h000, clkout_src_tick_r}, 12'h000, "other sources blocked");
    end
    clkout_src_ticks = 6'h00;
    // second reset in mid-run clears the enables again
    wr(`ACD_OFS_CONV_EN, 8'haa);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    rd(`ACD_OFS_CONV_EN, 8'h00);
    give_verdict;
  end
endmodule : tb
